// file: design/rcl_cfg.svh
// constants for the reset control logic
`ifndef RCL_CFG_SVH
`define RCL_CFG_SVH
`define RCL_FIRST_CYCLE_DELAY 4'ha
`define RCL_VEC_TABLE_BYTES 11'h400
`define RCL_VEC_COUNT 9'h100
`define RCL_VEC_SHIFT 2
`define RCL_MIN_ASSERT 4'h4
`endif

// file: design/rcl_pkg.sv
// types for the reset control logic
package rcl_pkg;
    typedef enum logic [1:0] {
        RCL_RUN = 2'h0,
        RCL_PEND = 2'h1,
        RCL_HOLD = 2'h3,
        RCL_BOOT = 2'h2
    } rcl_state_t;
    typedef struct packed {
        logic mst;
        logic clk;
        logic ext;
    } rcl_lines_t;
endpackage : rcl_pkg

// file: design/rcl_sync_if.sv
// carrier between pin synchroniser and the controller
interface rcl_sync_if;
    logic ext_req;
    logic clk_seen;
    modport src (output ext_req, output clk_seen);
    modport dst (input ext_req, input clk_seen);
endinterface : rcl_sync_if

// file: design/rcl_pin_sync.sv
// two-stage synchroniser for the external reset pin
module rcl_pin_sync (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ext_reset_pin_n,
    rcl_sync_if.src sync
);
    logic s1_ff, s2_ff, seen_ff;
    logic nxt_s1, nxt_s2, nxt_seen;
    always_comb begin
        nxt_s1 = ~ext_reset_pin_n;
        nxt_s2 = s1_ff;
        nxt_seen = 1'b1;
    end
    // power-on flops would run only once the clock runs, so a pin
    // held without a clock waits for the first edges
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            seen_ff <= 1'b0;
        end else begin
            s1_ff <= nxt_s1; // RL1
            s2_ff <= nxt_s2; // RL1
            seen_ff <= nxt_seen; // RL2
        end
    end
    assign sync.ext_req = s2_ff & seen_ff; // RL2
    assign sync.clk_seen = seen_ff;
endmodule : rcl_pin_sync

// file: design/rcl_reset_ctrl.sv
// reset control logic of the system integration unit
// What this block does
// RL1: external pin low passes synchroniser first
// RL2: no clock means reset waits for clock
// RL3: four outputs: pin, clock, master, instruction
// RL4: outputs move on clock; async acts immediately
// RL5: sync requests wait for bus cycle end
// RL6: pending sync reset forces bus monitor on
// RL7: halt asserts master, clock, pin together
// RL8: reset instruction is async, not catastrophic
// RL9: instruction indication separate from master reset
// RL10: reset beats exceptions, aborted work dropped
// RL11: writes in progress finish before sync reset
// RL12: validate, assert, latch straps, release processor
// RL13: vector table 1024 bytes, 256 entries
// RL14: strap low at reset selects slave test mode
// RL15: first bus cycle ten clocks after the reset lines release
// RL16: simultaneous sources assert union of lines
module rcl_reset_ctrl
    import rcl_pkg::*;
#(
    parameter int unsigned FIRST_DELAY = 10,
    parameter int unsigned MIN_ASSERT = 4
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ext_reset_pin_n,
    input wire logic power_up_req,
    input wire logic watchdog_req,
    input wire logic halt_req,
    input wire logic clock_loss_req,
    input wire logic test_req,
    input wire logic reset_instr_req,
    input wire logic bus_cycle_end,
    input wire logic test_strap_line,
    input wire logic bus_grant_out,
    input wire logic [7:0] vector_number,
    input wire logic [31:0] vector_base_pointer,
    output logic bus_clock_output,
    output logic ext_pin_reset_drive,
    output logic clock_module_reset,
    output logic master_reset_line,
    output logic reset_instr_indication,
    output logic bus_monitor_force,
    output logic exception_override,
    output logic cpu_release,
    output logic first_bus_cycle_ok,
    output logic slave_test_mode,
    output logic slave_access_en,
    output logic [31:0] vector_fetch_addr
);
`include "rcl_cfg.svh"
    rcl_sync_if sync_bus ();
    rcl_pin_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .ext_reset_pin_n(ext_reset_pin_n),
        .sync(sync_bus)
    );

    // =========================================================
    // source classification
    function automatic rcl_lines_t lines_for(input logic async_full,
        input logic sync_full, input logic test_only);
        rcl_lines_t l;
        l.mst = async_full | sync_full | test_only;
        l.clk = async_full | sync_full;
        l.ext = async_full | sync_full | test_only;
        return l;
    endfunction : lines_for

    logic async_hit, sync_hit;
    rcl_lines_t async_lines, sync_lines;
    always_comb begin
        async_hit = power_up_req | watchdog_req | halt_req; // RL7
        sync_hit = sync_bus.ext_req | clock_loss_req | test_req;
        async_lines = lines_for(async_hit, 1'b0, 1'b0); // RL7
        sync_lines = lines_for(1'b0, sync_bus.ext_req | clock_loss_req,
            test_req);
    end

    // =========================================================
    // sequencer
    rcl_state_t state_ff, nxt_state;
    rcl_lines_t lines_ff, nxt_lines;
    logic [3:0] cnt_ff, nxt_cnt;
    logic instr_ff, nxt_instr;
    logic strap_ff, nxt_strap;
    logic ok_ff, nxt_ok;

    always_comb begin
        nxt_state = state_ff;
        nxt_lines = lines_ff;
        nxt_cnt = cnt_ff;
        nxt_strap = strap_ff;
        nxt_ok = ok_ff;
        nxt_instr = reset_instr_req; // RL8 RL9
        case (state_ff)
            RCL_RUN: begin
                if (async_hit) begin
                    nxt_lines = async_lines | sync_lines; // RL4 RL16
                    nxt_state = RCL_HOLD;
                    nxt_cnt = 4'(MIN_ASSERT);
                    nxt_ok = 1'b0;
                end else if (sync_hit) begin
                    nxt_state = RCL_PEND; // RL5
                end
            end
            RCL_PEND: begin
                if (async_hit || bus_cycle_end) begin // RL5 RL11
                    nxt_lines = async_lines | sync_lines; // RL16
                    nxt_state = RCL_HOLD;
                    nxt_cnt = 4'(MIN_ASSERT);
                    nxt_ok = 1'b0;
                end else if (!sync_hit) begin
                    nxt_state = RCL_RUN;
                end
            end
            RCL_HOLD: begin
                nxt_lines = lines_ff | async_lines | sync_lines; // RL16
                nxt_strap = ~test_strap_line; // RL12 RL14
                if (cnt_ff != 4'h0) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else if (!async_hit && !sync_hit) begin
                    nxt_lines = '0;
                    nxt_state = RCL_BOOT;
                    nxt_cnt = 4'(FIRST_DELAY); // RL15
                end
            end
            RCL_BOOT: begin
                if (async_hit) begin
                    nxt_lines = async_lines; // RL10
                    nxt_state = RCL_HOLD;
                    nxt_cnt = 4'(MIN_ASSERT);
                end else if (cnt_ff > 4'h1) begin
                    nxt_cnt = cnt_ff - 4'h1;
                end else begin
                    nxt_ok = 1'b1; // RL15
                    nxt_state = RCL_RUN;
                end
            end
            default: begin
                nxt_state = RCL_HOLD;
            end
        endcase
    end

    // the on-chip reset is sampled synchronously as well; the reset lines and status flags move
    // on the bus clock so nothing glitches mid cycle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_ff <= RCL_HOLD;
            lines_ff <= '1;
            cnt_ff <= 4'(MIN_ASSERT);
            instr_ff <= 1'b0;
            strap_ff <= 1'b0;
            ok_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            lines_ff <= nxt_lines; // RL4
            cnt_ff <= nxt_cnt;
            instr_ff <= nxt_instr;
            strap_ff <= nxt_strap;
            ok_ff <= nxt_ok;
        end
    end

    // =========================================================
    // outputs
    always_comb begin
        bus_clock_output = core_clk;
        ext_pin_reset_drive = lines_ff.ext | instr_ff; // RL3 RL8
        clock_module_reset = lines_ff.clk; // RL3
        master_reset_line = lines_ff.mst; // RL3
        reset_instr_indication = instr_ff; // RL3 RL9
        bus_monitor_force = state_ff == RCL_PEND; // RL6
        exception_override = state_ff != RCL_RUN; // RL10
        cpu_release = state_ff == RCL_RUN; // RL12
        first_bus_cycle_ok = ok_ff; // RL15
        slave_test_mode = strap_ff; // RL14
        slave_access_en = strap_ff & bus_grant_out; // RL14
        // byte offset of four-byte vectors within a 1024-byte table
        vector_fetch_addr = vector_base_pointer
            + {22'h0, vector_number, 2'h0}; // RL13
    end

    // =========================================================
    // checks
    sequence s_pend_then_end;
        state_ff == RCL_PEND ##0 bus_cycle_end;
    endsequence
    a_async_immediate: assert property (@(posedge core_clk)
        disable iff (!reset_n) halt_req |=> master_reset_line
        && clock_module_reset && ext_pin_reset_drive) // RL7
        else $error("halt did not assert three lines");
    a_sync_waits_end: assert property (@(posedge core_clk)
        disable iff (!reset_n) (state_ff == RCL_PEND && !bus_cycle_end
        && !async_hit && sync_hit) |=> !master_reset_line) // RL5
        else $error("sync reset before cycle end");
    a_sync_applies: assert property (@(posedge core_clk)
        disable iff (!reset_n) s_pend_then_end |=> master_reset_line) // RL5
        else $error("sync reset not applied at cycle end");
    a_monitor_forced: assert property (@(posedge core_clk)
        disable iff (!reset_n) state_ff == RCL_PEND |-> bus_monitor_force) // RL6
        else $error("bus monitor not forced");
    a_instr_separate: assert property (@(posedge core_clk)
        disable iff (!reset_n) (reset_instr_req && state_ff == RCL_RUN
        && !async_hit && !sync_hit) |=> reset_instr_indication
        && !master_reset_line) // RL8
        else $error("reset instruction misrouted");
    a_test_no_clk: assert property (@(posedge core_clk)
        disable iff (!reset_n) (test_req && !async_hit
        && !sync_bus.ext_req && !clock_loss_req && state_ff == RCL_HOLD
        && !lines_ff.clk) |=> !clock_module_reset) // RL16
        else $error("test reset hit clock module");
    a_first_cycle: assert property (@(posedge core_clk)
        disable iff (!reset_n) ($fell(master_reset_line) && !async_hit)
        |-> !first_bus_cycle_ok [*8]) // RL15
        else $error("first bus cycle too early");
    a_ext_sync: assert property (@(posedge core_clk)
        disable iff (!reset_n) $fell(ext_reset_pin_n) |=>
        !sync_bus.ext_req) // RL1
        else $error("pin used without synchroniser");
    a_slave_grant: assert property (@(posedge core_clk)
        disable iff (!reset_n) slave_access_en |-> bus_grant_out
        && slave_test_mode) // RL14
        else $error("slave access without grant");
endmodule : rcl_reset_ctrl

// file: tb/rcl_ext_model.sv
// external reset circuitry and mode strap logic beside the controller
module rcl_ext_model (
    input wire logic pin_req,
    input wire logic strap_req,
    output logic ext_reset_pin_n,
    output logic test_strap_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // ===================================================================
    // pins
    // released lines float to their pull-up level, never the last value
    assign ext_reset_pin_n = pin_req ? 1'b0 : 1'b1;
    // strap is let go before the first bus cycle to avoid bus contention
    assign test_strap_line = strap_req ? 1'b0 : 1'b1;
endmodule : rcl_ext_model

// file: tb/testbench.sv
// self-checking testbench for the reset control logic
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FD = 10;
    logic core_clk = 1'b0, reset_n = 1'b0, pin_req = 1'b0, strap_req = 1'b1;
    logic [4:0] src = 5'h00;
    logic reset_instr_req = 1'b0, bus_cycle_end = 1'b0, bus_grant_out = 1'b0;
    logic [7:0] vector_number = 8'h00;
    logic [31:0] vector_base_pointer = 32'h00000000;
    logic ext_reset_pin_n, test_strap_line, bco, ext_d, clk_r, mst_r, instr;
    logic mon, exo, rel, fbc, stm, sae;
    logic [31:0] vfa;
    int num_errors = 0, compares = 0;
    always #25 core_clk = ~core_clk;
    rcl_ext_model model (.pin_req(pin_req), .strap_req(strap_req),
        .ext_reset_pin_n(ext_reset_pin_n), .test_strap_line(test_strap_line));
    rcl_reset_ctrl #(.FIRST_DELAY(FD), .MIN_ASSERT(4)) uut (
        .core_clk(core_clk), .reset_n(reset_n),
        .ext_reset_pin_n(ext_reset_pin_n), .power_up_req(src[0]),
        .watchdog_req(src[1]), .halt_req(src[2]), .clock_loss_req(src[3]),
        .test_req(src[4]), .reset_instr_req(reset_instr_req),
        .bus_cycle_end(bus_cycle_end), .test_strap_line(test_strap_line),
        .bus_grant_out(bus_grant_out), .vector_number(vector_number),
        .vector_base_pointer(vector_base_pointer), .bus_clock_output(bco),
        .ext_pin_reset_drive(ext_d), .clock_module_reset(clk_r),
        .master_reset_line(mst_r), .reset_instr_indication(instr),
        .bus_monitor_force(mon), .exception_override(exo),
        .cpu_release(rel), .first_bus_cycle_ok(fbc), .slave_test_mode(stm),
        .slave_access_en(sae), .vector_fetch_addr(vfa));
    // ===================================================================
    // reporting and shared checks
    task print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // lines are sampled at the falling edge so that edge updates have landed
    task wait_lines(input int bound, input logic [2:0] exp);
        int n;
        n = 0;
        @(negedge core_clk);
        while ({mst_r, clk_r, ext_d} !== exp && n < bound) begin
            @(negedge core_clk);
            n++;
        end
        chk("reset lines", {29'h0, exp}, {29'h0, mst_r, clk_r, ext_d});
        if (n >= bound) print_verdict;
    endtask : wait_lines
    // sync sources are ignored during the boot delay, so wait for release first
    task wait_release;
        int n;
        n = 0;
        @(negedge core_clk);
        while (rel !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("cpu release", 1, rel);
        if (n >= 40) print_verdict;
    endtask : wait_release
    // ===================================================================
    // scenarios
    task boot_check;
        int n;
        wait_lines(20, 3'h0);
        n = 1;
        @(posedge core_clk) strap_req <= 1'b0;
        @(negedge core_clk);
        while (fbc !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk("boot delay", FD, n);
        if (n >= 40) print_verdict;
        chk("slave mode", 1, stm);
        @(posedge core_clk) bus_grant_out <= 1'b1;
        @(negedge core_clk) chk("slave access", 1, sae);
    endtask : boot_check
    task vector_check;
        @(posedge core_clk);
        vector_base_pointer <= 32'h00010000;
        vector_number <= 8'hff;
        @(negedge core_clk) chk("vector addr", 32'h000103fc, vfa);
        chk("bus clock", 0, bco);
    endtask : vector_check
    task run_source(input int idx, input logic [2:0] exp);
        if (idx >= 3) wait_release;
        @(posedge core_clk);
        if (idx == 5) pin_req <= 1'b1;
        else src[idx] <= 1'b1;
        if (idx < 3) begin
            @(posedge core_clk);
            @(negedge core_clk) chk("async lines", exp, {mst_r, clk_r, ext_d});
        end else begin
            repeat (4) @(negedge core_clk);
            chk("held lines", 0, {mst_r, clk_r, ext_d});
            chk("monitor force", 1, mon);
            @(posedge core_clk) bus_cycle_end <= 1'b1;
            @(posedge core_clk) bus_cycle_end <= 1'b0;
            wait_lines(3, exp);
        end
        chk("override", 1, exo);
        @(posedge core_clk);
        pin_req <= 1'b0;
        src <= 5'h00;
        wait_lines(30, 3'h0);
    endtask : run_source
    task instr_check;
        wait_release;
        @(posedge core_clk) reset_instr_req <= 1'b1;
        @(posedge core_clk) reset_instr_req <= 1'b0;
        @(negedge core_clk) chk("instr ind", 1, instr);
        chk("master quiet", 0, mst_r);
        chk("instr pin", 1, ext_d);
        @(negedge core_clk) chk("instr clear", 0, instr);
        chk("slave mode off", 0, stm);
    endtask : instr_check
    // ===================================================================
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        boot_check;
        vector_check;
        for (int i = 0; i < 6; i++) begin
            run_source(i, (i == 4) ? 3'h5 : 3'h7);
        end
        instr_check;
        print_verdict;
    end
endmodule : testbench
